// ---- pkg/cam_pkg.sv ----
// Package: addressing mode codes, prefix values and decoder state types
package cam_pkg;

	// ----------------------------------------
	// Prefix bytes and address constants
	// ----------------------------------------
	localparam logic [7:0]  SECOND_INDEX_PREFIX          = 8'h90;
	localparam logic [7:0]  INDIRECT_SECOND_INDEX_PREFIX = 8'h91;
	localparam logic [7:0]  INDIRECT_PREFIX              = 8'h92;
	localparam logic [7:0]  NO_PREFIX                    = 8'h00;
	localparam logic [7:0]  PAGE_ZERO_HI                 = 8'h00;
	localparam logic [15:0] REL_FWD_MAX                  = 16'h007F;
	localparam logic [15:0] REL_BACK_MIN                 = 16'hFF80;
	localparam logic [15:0] SHORT_IDX_MAX                = 16'h01FE;
	localparam logic [2:0]  OPCODE_LEN                   = 3'h1;

	// ----------------------------------------
	// Addressing modes (seventeen, seven families)
	// ----------------------------------------
	typedef enum logic [4:0] {
		CAM_INH, CAM_IMM,
		CAM_DIR_S, CAM_DIR_L,
		CAM_IDX_0, CAM_IDX_S, CAM_IDX_L,
		CAM_IND_S, CAM_IND_L, CAM_IIX_S, CAM_IIX_L,
		CAM_REL_D, CAM_REL_I,
		CAM_BIT_D, CAM_BIT_I, CAM_BTJ_D, CAM_BTJ_I
	} cam_mode_t;

	typedef enum logic [1:0] {
		CAM_IDLE, CAM_OPND, CAM_PTR, CAM_CALC
	} cam_state_t;

	typedef struct packed {
		cam_state_t  st;
		cam_mode_t   mode;
		logic        pfx;
		logic [7:0]  idx;
		logic [15:0] pc;
		logic [15:0] npc;
		logic [1:0]  cnt;
		logic [1:0]  nop;
		logic [7:0]  op0;
		logic [7:0]  op1;
		logic [7:0]  p0;
		logic [7:0]  p1;
		logic        req;
		logic [15:0] raddr;
		logic [2:0]  len;
		logic [15:0] ea;
		logic [15:0] tgt;
		logic [7:0]  opnd;
		logic        ill;
		logic        done;
	} cam_dec_t;

	typedef struct packed {
		logic        busy;
		logic [15:0] addr;
		logic [7:0]  data;
		logic        done;
	} cam_rd_t;

endpackage

// ---- pkg/cam_rd_if.sv ----
// Interface: byte read requests from the decoder to the bus reader
`timescale 1ns/1ns
`default_nettype none
interface cam_rd_if;
	logic        req;
	logic [15:0] addr;
	logic [7:0]  data;
	logic        done;
	modport client (output req, output addr, input data, input done);
	modport server (input req, input addr, output data, output done);
endinterface
`default_nettype wire

// ---- hdl/cam_fetch.sv ----
// Single byte reader on the core bus
`timescale 1ns/1ns
`default_nettype none
module cam_fetch
(
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   srst,
	// Decoder side
	cam_rd_if.server    rd,
	// Core bus
	output logic        mem_rd,
	output logic [15:0] mem_addr,
	input  wire logic [7:0] mem_rdata,
	input  wire logic   mem_ack
);
	import cam_pkg::*;

	cam_rd_t cur_reg;
	cam_rd_t cur_next;

	always_comb
	begin
		cur_next      = cur_reg;
		cur_next.done = 1'b0;
		if (cur_reg.busy && mem_ack)
		begin
			cur_next.busy = 1'b0;
			cur_next.data = mem_rdata;
			cur_next.done = 1'b1;
		end
		else if (!cur_reg.busy && rd.req)
		begin
			cur_next.busy = 1'b1;
			cur_next.addr = rd.addr;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			cur_reg <= '0;
		else
			cur_reg <= cur_next;
	end

	assign mem_rd   = cur_reg.busy;
	assign mem_addr = cur_reg.addr;
	assign rd.data  = cur_reg.data;
	assign rd.done  = cur_reg.done;
endmodule // cam_fetch
`default_nettype wire

// ---- hdl/cam_decode.sv ----
// Operand addressing decoder: length and effective address per mode
// Functional notes
// - Seventeen addressing modes in seven families are decoded.
// - Long forms reach all 64 Kbyte; long direct and long indexed cost one extra byte.
// - Short direct and indirect forms stay in page zero, 0000h to 00FFh.
// - Read-modify-write operations are accepted only in short forms.
// - Inherent instructions are exactly one byte.
// - Immediate is two bytes; second byte is the operand.
// - Short direct byte is the operand address, 00 to FF.
// - Long direct two bytes form the word address.
// - Indexed address is unsigned sum of index and offset.
// - No-offset indexed uses the index alone, no extra byte.
// - Second index register form costs one more byte.
// - Short indexed byte offset plus index reaches up to 1FE.
// - Long indexed adds a two-byte word offset to the index.
// - Indirect byte is a page-zero pointer address, pointer fetched.
// - Short indirect pointer is one byte, operand within 00 to FF.
// - Long indirect pointers are words; pointer address stays a byte.
// - Indirect indexed address is index plus fetched pointer.
// - Short indirect indexed byte pointer plus index reaches 1FE.
// - Relative targets lie within next PC minus 128 to plus 127.
// - Relative adds a signed byte offset, direct or fetched.
// - Prefix bytes select second index, indirect, or both.
`timescale 1ns/1ns
`default_nettype none
module cam_decode
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// Decode request
	input  wire logic               start,
	input  wire cam_pkg::cam_mode_t base_mode,
	input  wire logic [7:0]         prefix,
	input  wire logic               rmw,
	input  wire logic [15:0]        pc,
	input  wire logic [7:0]         idx_x,
	input  wire logic [7:0]         idx_y,
	// Decode result
	output logic                    busy,
	output logic                    done,
	output logic                    illegal,
	output logic [2:0]              length,
	output logic [15:0]             eff_addr,
	output logic [15:0]             branch_target,
	output logic [7:0]              operand,
	// Core bus
	output logic                    mem_rd,
	output logic [15:0]             mem_addr,
	input  wire logic [7:0]         mem_rdata,
	input  wire logic               mem_ack
);
	import cam_pkg::*;

	// ----------------------------------------
	// Mode tables
	// ----------------------------------------
	function automatic logic [1:0] follow_bytes(input cam_mode_t m);
		unique case (m)
			CAM_INH, CAM_IDX_0:                         return 2'h0;
			CAM_DIR_L, CAM_IDX_L, CAM_BTJ_D, CAM_BTJ_I: return 2'h2;
			default:                                    return 2'h1;
		endcase
	endfunction

	function automatic logic is_ptr(input cam_mode_t m);
		return m inside {CAM_IND_S, CAM_IND_L, CAM_IIX_S, CAM_IIX_L,
			CAM_REL_I, CAM_BIT_I, CAM_BTJ_I};
	endfunction

	function automatic logic is_long(input cam_mode_t m);
		return m inside {CAM_DIR_L, CAM_IDX_L, CAM_IND_L, CAM_IIX_L};
	endfunction

	function automatic logic [15:0] rel(input logic [15:0] npc, input logic [7:0] off);
		return npc + {{8{off[7]}}, off};
	endfunction

	// Direct form to its indirect counterpart
	function automatic cam_mode_t to_ind(input cam_mode_t m);
		unique case (m)
			CAM_DIR_S: return CAM_IND_S;
			CAM_DIR_L: return CAM_IND_L;
			CAM_IDX_S: return CAM_IIX_S;
			CAM_IDX_L: return CAM_IIX_L;
			CAM_REL_D: return CAM_REL_I;
			CAM_BIT_D: return CAM_BIT_I;
			CAM_BTJ_D: return CAM_BTJ_I;
			default:   return m;
		endcase
	endfunction

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	cam_rd_if rd ();
	cam_dec_t cur_reg;
	cam_dec_t cur_next;
	cam_mode_t eff_mode;
	logic      use_y;
	logic      bad;

	always_comb
	begin
		eff_mode = base_mode;
		use_y    = 1'b0;
		bad      = 1'b0;
		unique case (prefix)
			NO_PREFIX: ;
			SECOND_INDEX_PREFIX:
			begin
				use_y = 1'b1;
				bad   = base_mode inside {CAM_REL_D, CAM_BIT_D, CAM_BTJ_D};
			end
			INDIRECT_PREFIX:
			begin
				eff_mode = to_ind(base_mode);
				bad      = (to_ind(base_mode) == base_mode);
			end
			INDIRECT_SECOND_INDEX_PREFIX:
			begin
				use_y    = 1'b1;
				eff_mode = to_ind(base_mode);
				bad      = !(base_mode inside {CAM_IDX_S, CAM_IDX_L});
			end
			default: bad = 1'b1;
		endcase
		// Read-modify-write operations only in short forms
		if (rmw && is_long(eff_mode))
			bad = 1'b1;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic [7:0] a0;
	logic [7:0] a1;
	logic [7:0] q0;

	always_comb
	begin
		cur_next      = cur_reg;
		cur_next.req  = 1'b0;
		cur_next.done = 1'b0;
		a0 = cur_reg.op0;
		a1 = cur_reg.op1;
		q0 = cur_reg.p0;
		unique case (cur_reg.st)
			CAM_IDLE:
			begin
				if (start)
				begin
					cur_next.mode = eff_mode;
					cur_next.pfx  = (prefix != NO_PREFIX);
					cur_next.idx  = use_y ? idx_y : idx_x;
					cur_next.pc   = pc;
					cur_next.nop  = follow_bytes(eff_mode);
					cur_next.cnt  = 2'h0;
					// Prefix byte counts toward length
					cur_next.len  = OPCODE_LEN + {1'b0, follow_bytes(eff_mode)}
						+ {2'h0, prefix != NO_PREFIX};
					cur_next.npc  = pc + {14'h0, follow_bytes(eff_mode)} + 16'h0001;
					cur_next.ill  = bad;
					if (bad)
						cur_next.done = 1'b1;
					else if (follow_bytes(eff_mode) == 2'h0)
						cur_next.st = CAM_CALC;
					else
					begin
						cur_next.st    = CAM_OPND;
						cur_next.req   = 1'b1;
						cur_next.raddr = pc + 16'h0001;
					end
				end
			end
			CAM_OPND:
			begin
				if (rd.done)
				begin
					if (cur_reg.cnt == 2'h0)
						cur_next.op0 = rd.data;
					else
						cur_next.op1 = rd.data;
					cur_next.cnt = cur_reg.cnt + 2'h1;
					if (cur_reg.cnt + 2'h1 < cur_reg.nop)
					begin
						cur_next.req   = 1'b1;
						cur_next.raddr = cur_reg.pc + 16'h0002;
					end
					else if (is_ptr(cur_reg.mode))
					begin
						// Pointer always lives in page zero
						cur_next.st    = CAM_PTR;
						cur_next.cnt   = 2'h0;
						cur_next.req   = 1'b1;
						cur_next.raddr = {PAGE_ZERO_HI,
							(cur_reg.cnt == 2'h0) ? rd.data : cur_reg.op0};
					end
					else
						cur_next.st = CAM_CALC;
				end
			end
			CAM_PTR:
			begin
				if (rd.done)
				begin
					if (cur_reg.cnt == 2'h0)
						cur_next.p0 = rd.data;
					else
						cur_next.p1 = rd.data;
					cur_next.cnt = cur_reg.cnt + 2'h1;
					// Word pointer, high byte first; stays in page zero
					if (cur_reg.cnt == 2'h0 && cur_reg.mode inside {CAM_IND_L, CAM_IIX_L})
					begin
						cur_next.req   = 1'b1;
						cur_next.raddr = {PAGE_ZERO_HI, cur_reg.op0 + 8'h01};
					end
					else
						cur_next.st = CAM_CALC;
				end
			end
			CAM_CALC:
			begin
				cur_next.st   = CAM_IDLE;
				cur_next.done = 1'b1;
				cur_next.tgt  = cur_reg.npc;
				cur_next.opnd = a0;
				unique case (cur_reg.mode)
					CAM_INH:   cur_next.ea = cur_reg.pc;
					CAM_IMM:   cur_next.ea = cur_reg.pc + 16'h0001;
					CAM_DIR_S, CAM_BIT_D: cur_next.ea = {PAGE_ZERO_HI, a0};
					CAM_DIR_L: cur_next.ea = {a0, a1};
					CAM_IDX_0: cur_next.ea = {PAGE_ZERO_HI, cur_reg.idx};
					CAM_IDX_S: cur_next.ea = {8'h00, a0} + {8'h00, cur_reg.idx};
					CAM_IDX_L: cur_next.ea = {a0, a1} + {8'h00, cur_reg.idx};
					CAM_IND_S, CAM_BIT_I: cur_next.ea = {PAGE_ZERO_HI, q0};
					CAM_IND_L: cur_next.ea = {q0, cur_reg.p1};
					CAM_IIX_S: cur_next.ea = {8'h00, q0} + {8'h00, cur_reg.idx};
					CAM_IIX_L: cur_next.ea = {q0, cur_reg.p1} + {8'h00, cur_reg.idx};
					CAM_REL_D:
					begin
						cur_next.ea  = cur_reg.pc + 16'h0001;
						cur_next.tgt = rel(cur_reg.npc, a0);
					end
					CAM_REL_I:
					begin
						cur_next.ea  = {PAGE_ZERO_HI, a0};
						cur_next.tgt = rel(cur_reg.npc, q0);
					end
					CAM_BTJ_D:
					begin
						cur_next.ea  = {PAGE_ZERO_HI, a0};
						cur_next.tgt = rel(cur_reg.npc, a1);
					end
					CAM_BTJ_I:
					begin
						cur_next.ea  = {PAGE_ZERO_HI, q0};
						cur_next.tgt = rel(cur_reg.npc, a1);
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			cur_reg <= '0;
		else
			cur_reg <= cur_next;
	end

	// ----------------------------------------
	// Bus reader and outputs
	// ----------------------------------------
	assign rd.req  = cur_reg.req;
	assign rd.addr = cur_reg.raddr;

	cam_fetch u_cam_fetch
	(
		.clk       (clk),
		.srst      (srst),
		.rd        (rd),
		.mem_rd    (mem_rd),
		.mem_addr  (mem_addr),
		.mem_rdata (mem_rdata),
		.mem_ack   (mem_ack)
	);

	assign busy          = (cur_reg.st != CAM_IDLE);
	assign done          = cur_reg.done;
	assign illegal       = cur_reg.ill;
	assign length        = cur_reg.len;
	assign eff_addr      = cur_reg.ea;
	assign branch_target = cur_reg.tgt;
	assign operand       = cur_reg.opnd;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic [15:0] rel_d;
	assign rel_d = cur_reg.tgt - cur_reg.npc;

	property p_inh_len;
		done && !illegal && cur_reg.mode == CAM_INH |-> length == 3'h1;
	endproperty
	a_inh_len: assert property (p_inh_len) else $error("inherent length not one");

	property p_imm;
		done && !illegal && cur_reg.mode == CAM_IMM |->
			length == 3'h2 + {2'h0, cur_reg.pfx} && operand == cur_reg.op0;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate decode wrong");

	property p_dir_s;
		done && cur_reg.mode == CAM_DIR_S && !illegal |-> eff_addr == {8'h00, cur_reg.op0};
	endproperty
	a_dir_s: assert property (p_dir_s) else $error("short direct outside page zero");

	property p_dir_l;
		done && cur_reg.mode == CAM_DIR_L && !illegal |-> eff_addr == {cur_reg.op0, cur_reg.op1};
	endproperty
	a_dir_l: assert property (p_dir_l) else $error("long direct word wrong");

	property p_idx_short;
		done && !illegal && cur_reg.mode inside {CAM_IDX_S, CAM_IIX_S} |->
			eff_addr <= SHORT_IDX_MAX;
	endproperty
	a_idx_short: assert property (p_idx_short) else $error("short indexed out of range");

	property p_rmw_long;
		start && !busy && rmw && is_long(eff_mode) |=> done && illegal;
	endproperty
	a_rmw_long: assert property (p_rmw_long) else $error("long form accepted for rmw");

	property p_ptr_page0;
		cur_reg.st == CAM_PTR && mem_rd |-> mem_addr[15:8] == PAGE_ZERO_HI;
	endproperty
	a_ptr_page0: assert property (p_ptr_page0) else $error("pointer read off page zero");

	property p_rel_range;
		done && !illegal && cur_reg.mode inside {CAM_REL_D, CAM_REL_I} |->
			(rel_d <= REL_FWD_MAX || rel_d >= REL_BACK_MIN);
	endproperty
	a_rel_range: assert property (p_rel_range) else $error("branch target out of range");

	property p_start_busy;
		start && !busy && !bad |=> busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("legal request not taken");

	c_long_ind: cover property (done && cur_reg.mode == CAM_IIX_L);
	c_rel_ind:  cover property (done && cur_reg.mode == CAM_REL_I);
	c_illegal:  cover property (done && illegal);
endmodule // cam_decode
`default_nettype wire

// ---- verif/cam_mem_model.sv ----
// Behavioural core bus memory answering the decoder's byte reads
`timescale 1ns/1ns
`default_nettype none
module cam_mem_model
(
	// Clock
	input  wire logic        clk,
	// Core bus
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output logic [7:0]       mem_rdata,
	output logic             mem_ack,
	// Answer delay in cycles
	input  wire logic [3:0]  lat
);
	logic [7:0] mem [0:65535];
	logic [3:0] wait_reg;
	initial
	begin
		mem_rdata = 8'h00;
		mem_ack = 1'b0;
		wait_reg = 4'h0;
	end
	// Idle data toggles so a stale byte never passes for a fresh one
	always @(posedge clk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_rd && !mem_ack)
		begin
			if (wait_reg == lat)
			begin
				mem_ack <= 1'b1;
				mem_rdata <= mem[mem_addr];
				wait_reg <= 4'h0;
			end
			else
				wait_reg <= wait_reg + 4'h1;
		end
		// A read cut short by reset must not leave a partial wait behind
		else
			wait_reg <= 4'h0;
	end
endmodule // cam_mem_model
`default_nettype wire

// ---- verif/cam_decode_tb.sv ----
// Self-checking bench for the addressing mode decoder
`timescale 1ns/1ns
`default_nettype none
module cam_decode_tb;
	import cam_pkg::*;
	logic        clk, srst, start, rmw, busy, done, illegal, mem_rd, mem_ack;
	cam_mode_t   base_mode;
	logic [7:0]  prefix, idx_x, idx_y, operand, mem_rdata, ix, iy;
	logic [15:0] pc, eff_addr, branch_target, mem_addr;
	logic [2:0]  length;
	logic [3:0]  lat;
	int          n_fail, checked, n_rd;

	cam_decode u_cam_decode (.clk(clk), .srst(srst), .start(start), .base_mode(base_mode),
		.prefix(prefix), .rmw(rmw), .pc(pc), .idx_x(idx_x), .idx_y(idx_y), .busy(busy),
		.done(done), .illegal(illegal), .length(length), .eff_addr(eff_addr),
		.branch_target(branch_target), .operand(operand), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	cam_mem_model u_cam_mem_model (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (mem_rd === 1'b1)
			n_rd <= n_rd + 1;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [15:0] ex, input logic [15:0] got);
		checked++;
		if (got !== ex)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", s, ex, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		u_cam_mem_model.mem[a] = d;
	endtask
	// Illegal requests skip length and target; e selects the address compare
	task automatic dec(input cam_mode_t m, input logic [7:0] pf, input logic rw,
		input logic [15:0] p, input logic il, input logic e, input logic [2:0] ln,
		input logic [15:0] ea, input logic [15:0] tg);
		int k;
		@(posedge clk);
		base_mode <= m;
		prefix <= pf;
		rmw <= rw;
		pc <= p;
		idx_x <= ix;
		idx_y <= iy;
		start <= 1'b1;
		for (k = 0; k < 300; k++)
		begin
			@(posedge clk);
			start <= 1'b0;
			#1;
			if (k == 0)
				chk("busy", {15'h0000, !il}, {15'h0000, busy});
			if (done === 1'b1)
				break;
		end
		chk("done", 16'h0001, {15'h0000, done});
		chk("idle", 16'h0000, {15'h0000, busy});
		chk("illegal", {15'h0000, il}, {15'h0000, illegal});
		if (!il)
		begin
			chk("length", {13'h0000, ln}, {13'h0000, length});
			chk("target", tg, branch_target);
		end
		if (e)
			chk("eff_addr", ea, eff_addr);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset idles busy, mem_rd and eff_addr; a reset in mid-read has dropped the request two cycles on
	task automatic t_rst;
		#1;
		chk("busy", 16'h0000, {15'h0000, busy});
		chk("mem_rd", 16'h0000, {15'h0000, mem_rd});
		chk("eff_addr", 16'h0000, eff_addr);
		wr(16'h2001, 8'h7E);
		wr(16'h2002, 8'h34);
		@(posedge clk);
		base_mode <= CAM_DIR_L;
		prefix <= 8'h00;
		pc <= 16'h2000;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("busy", 16'h0000, {15'h0000, busy});
		chk("mem_rd", 16'h0000, {15'h0000, mem_rd});
		@(posedge clk);
		srst <= 1'b0;
		dec(CAM_DIR_L, 8'h00, 1'b0, 16'h2000, 1'b0, 1'b1, 3'h3, 16'h7E34, 16'h2003);
	endtask
	task automatic t_inh;
		ix = 8'h3C;
		iy = 8'hC5;
		dec(CAM_INH, 8'h00, 1'b0, 16'h1000, 1'b0, 1'b1, 3'h1, 16'h1000, 16'h1001);
		dec(CAM_IDX_0, 8'h00, 1'b0, 16'h1000, 1'b0, 1'b1, 3'h1, 16'h003C, 16'h1001);
		dec(CAM_IDX_0, 8'h90, 1'b0, 16'h1000, 1'b0, 1'b1, 3'h2, 16'h00C5, 16'h1001);
		wr(16'h1001, 8'hA5);
		dec(CAM_IMM, 8'h00, 1'b0, 16'h1000, 1'b0, 1'b1, 3'h2, 16'h1001, 16'h1002);
		chk("operand", 16'h00A5, {8'h00, operand});
	endtask
	task automatic t_dir;
		wr(16'h2001, 8'h7E);
		wr(16'h2002, 8'h34);
		dec(CAM_DIR_S, 8'h00, 1'b0, 16'h2000, 1'b0, 1'b1, 3'h2, 16'h007E, 16'h2002);
		dec(CAM_DIR_L, 8'h00, 1'b0, 16'h2000, 1'b0, 1'b1, 3'h3, 16'h7E34, 16'h2003);
	endtask
	// Slow memory here, so every read waits several cycles
	task automatic t_idx;
		lat <= 4'h3;
		ix = 8'hFF;
		iy = 8'h20;
		wr(16'h3001, 8'hFF);
		wr(16'h3002, 8'h12);
		dec(CAM_IDX_S, 8'h00, 1'b0, 16'h3000, 1'b0, 1'b1, 3'h2, 16'h01FE, 16'h3002);
		dec(CAM_IDX_S, 8'h90, 1'b0, 16'h3000, 1'b0, 1'b1, 3'h3, 16'h011F, 16'h3002);
		dec(CAM_IDX_L, 8'h90, 1'b0, 16'h3000, 1'b0, 1'b1, 3'h4, 16'hFF32, 16'h3003);
		lat <= 4'h0;
	endtask
	// Pointer at the top of page zero wraps to 0000 for its low byte
	task automatic t_ind;
		wr(16'h4001, 8'hFF);
		wr(16'h00FF, 8'h9A);
		wr(16'h0000, 8'hBC);
		dec(CAM_DIR_S, 8'h92, 1'b0, 16'h4000, 1'b0, 1'b1, 3'h3, 16'h009A, 16'h4002);
		dec(CAM_DIR_L, 8'h92, 1'b0, 16'h4000, 1'b0, 1'b1, 3'h3, 16'h9ABC, 16'h4002);
		dec(CAM_IDX_S, 8'h92, 1'b0, 16'h4000, 1'b0, 1'b1, 3'h3, 16'h0199, 16'h4002);
		dec(CAM_IDX_L, 8'h91, 1'b0, 16'h4000, 1'b0, 1'b1, 3'h3, 16'h9ADC, 16'h4002);
		dec(CAM_IDX_S, 8'h91, 1'b0, 16'h4000, 1'b0, 1'b1, 3'h3, 16'h00BA, 16'h4002);
	endtask
	task automatic t_branch;
		wr(16'h5001, 8'h80);
		wr(16'h0080, 8'h7F);
		dec(CAM_REL_D, 8'h00, 1'b0, 16'h5000, 1'b0, 1'b0, 3'h2, 16'h0000, 16'h4F82);
		dec(CAM_REL_D, 8'h92, 1'b0, 16'h5000, 1'b0, 1'b1, 3'h3, 16'h0080, 16'h5081);
		wr(16'h6001, 8'h44);
		wr(16'h6002, 8'h7F);
		wr(16'h0044, 8'h55);
		dec(CAM_BIT_D, 8'h00, 1'b0, 16'h6000, 1'b0, 1'b1, 3'h2, 16'h0044, 16'h6002);
		dec(CAM_BTJ_D, 8'h00, 1'b0, 16'h6000, 1'b0, 1'b1, 3'h3, 16'h0044, 16'h6082);
		dec(CAM_BIT_D, 8'h92, 1'b0, 16'h6000, 1'b0, 1'b1, 3'h3, 16'h0055, 16'h6002);
		dec(CAM_BTJ_D, 8'h92, 1'b0, 16'h6000, 1'b0, 1'b1, 3'h4, 16'h0055, 16'h6082);
	endtask
	// Refused requests must not touch the bus
	task automatic t_ill;
		int n0;
		n0 = n_rd;
		dec(CAM_DIR_S, 8'h93, 1'b0, 16'h2000, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h0000);
		dec(CAM_REL_D, 8'h90, 1'b0, 16'h5000, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h0000);
		dec(CAM_INH, 8'h92, 1'b0, 16'h1000, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h0000);
		dec(CAM_DIR_S, 8'h91, 1'b0, 16'h2000, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h0000);
		dec(CAM_DIR_L, 8'h00, 1'b1, 16'h2000, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h0000);
		dec(CAM_IDX_L, 8'h00, 1'b1, 16'h3000, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h0000);
		chk("reads", n0[15:0], n_rd[15:0]);
		dec(CAM_DIR_S, 8'h00, 1'b1, 16'h2000, 1'b0, 1'b1, 3'h2, 16'h007E, 16'h2002);
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial
	begin
		n_fail = 0;
		checked = 0;
		n_rd = 0;
		srst = 1'b1;
		start = 1'b0;
		base_mode = CAM_INH;
		prefix = 8'h00;
		rmw = 1'b0;
		pc = 16'h0000;
		idx_x = 8'h00;
		idx_y = 8'h00;
		lat = 4'h0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_rst();
		t_inh();
		t_dir();
		t_idx();
		t_ind();
		t_branch();
		t_ill();
		finish_test();
	end
endmodule // cam_decode_tb
`default_nettype wire
